// *** hdl/bsp_pkg.sv ***
// Purpose: constants for the sample/bypass scan port
// Assumes: tck sampled by clk_sys at 10 MHz
// Notes: instruction codes and chain widths
package bsp_pkg;
  localparam int BSP_IR_W = 3;
  localparam int BSP_BSR_W = 69;
  localparam logic [2:0] BSP_IR_EXTEST = 3'h0;
  localparam logic [2:0] BSP_IR_IDCODE = 3'h1;
  localparam logic [2:0] BSP_IR_SAMPLEZ = 3'h2;
  localparam logic [2:0] BSP_IR_SAMPLE = 3'h4;
  localparam logic [2:0] BSP_IR_BYPASS = 3'h7;
  localparam logic [1:0] BSP_IR_CAPTURE = 2'h1;
  localparam int BSP_ID_W = 32;
  // neutral identity value, arbitrary
  localparam logic [31:0] BSP_ID_DEFAULT = 32'h0000_0001;
  localparam int BSP_TMS_RESET_HITS = 5;
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PAU_DR = 16'h0040, ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PAU_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
  } bsp_state_t;
endpackage : bsp_pkg

// *** hdl/bsp_sync.sv ***
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: inputs asynchronous to clk_sys
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module bsp_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : bsp_sync

// *** hdl/bsp_tap.sv ***
// Purpose: scan test port with sample and bypass data paths
// Assumes: tck well below clk_sys; clk_sys samples every pin
// Notes: tck edges are found from the synchronised level
//
// Notes on behaviour
// - capture-dr under sample latches all input and bidirectional pin levels
// - no preload: shifted chain bits never reach pins or logic
// - shift-dr after sample capture shifts chain out, one bit per tck
// - update-dr under sample does nothing, same as pause-dr
// - bypass in shift-dr routes tdi to tdo through one-bit register
// - code 100 is sample, 111 bypass; 011, 101, 110 reserved
// - instruction register is three bits, shifted from tdi toward tdo
// - boundary chain 69 bits, msb at tdi, lsb drives tdo
// - tdi and tms taken on tck rise, tdo changes on tck fall
`timescale 1ns/1ps
module bsp_tap
  import bsp_pkg::*;
#(
  parameter int BSR_W = BSP_BSR_W,
  parameter logic [31:0] ID_VALUE = BSP_ID_DEFAULT
) (
  // system
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // scan pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  // pin levels presented to the boundary chain, bit 0 nearest tdo
  input wire logic [BSR_W-1:0] pin_levels,
  // instruction in force, for the rest of the device
  output logic [BSP_IR_W-1:0] instr_active
);
  // ----------------------------------------
  // input sampling
  // ----------------------------------------
  // tck, tms and tdi share one synchroniser, so the data pins are seen in the same
  // clk_sys cycle as the tck level that qualifies them; tdi may flip at the tck fall
  logic [2:0] raw_in;
  logic [2:0] sync_in;
  logic tck_prev_q;
  logic [BSR_W-1:0] pins_s;
  assign raw_in = {tck, tms, tdi};
  bsp_sync #(.W(3)) u_sync_ctl (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .async_in(raw_in), .sync_out(sync_in)
  );
  // the pins ride their own synchroniser; a pin moving near capture may land either
  // way, which is why a free-running memory clock bit cannot be trusted
  bsp_sync #(.W(BSR_W)) u_sync_pins (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .async_in(pin_levels), .sync_out(pins_s)
  );
  wire tck_s = sync_in[2];
  wire tms_s = sync_in[1];
  wire tdi_s = sync_in[0];
  // edge strobes last one clk_sys cycle; the previous level starts at the idle low of tck
  wire tck_rise = tck_s & ~tck_prev_q;
  wire tck_fall = ~tck_s & tck_prev_q;
  wire tck_step = clk_en & tck_rise;
  wire tck_drop = clk_en & tck_fall;

  // ----------------------------------------
  // controller
  // ----------------------------------------
  // plain sixteen-state walk; five rises with tms high reach reset from any state,
  // which is how the far side recovers from a scan abandoned half way
  // the walk advances only on a detected tck rise, so tms is read once per tck
  // even though clk_sys sees each tck level for several cycles
  bsp_state_t st_q, st_d;
  always_comb begin
    case (st_q)
      ST_RESET: st_d = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: st_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: st_d = tms_s ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: st_d = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: st_d = tms_s ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: st_d = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: st_d = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: st_d = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: st_d = tms_s ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
      default: st_d = ST_RESET;
    endcase
  end

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  logic [BSP_IR_W-1:0] ir_sh_q;
  logic [BSR_W-1:0] bsr_q;
  logic [BSP_ID_W-1:0] id_q;
  logic byp_q;
  // extest and sample-z also capture the ring here; reserved codes fall to bypass
  wire sel_bsr = (instr_active == BSP_IR_SAMPLE) || (instr_active == BSP_IR_EXTEST)
              || (instr_active == BSP_IR_SAMPLEZ);
  wire sel_id = (instr_active == BSP_IR_IDCODE);
  wire sel_byp = ~sel_bsr & ~sel_id;
  wire in_shift = (st_q == ST_SH_DR) || (st_q == ST_SH_IR);
  wire dr_bit = sel_bsr ? bsr_q[0] : (sel_id ? id_q[0] : byp_q);
  wire out_bit = (st_q == ST_SH_IR) ? ir_sh_q[0] : dr_bit;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tck_prev_q <= 1'b0;
      st_q <= ST_RESET;
    end else if (clk_en) begin
      tck_prev_q <= tck_s;
      if (tck_rise) st_q <= st_d;
    end
  end

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  // the shift stage and the instruction in force are kept apart, so a half-shifted
  // code never reaches the decoder; only update-ir moves it across
  wire tap_reset = (st_q == ST_RESET);
  wire ir_capture = (st_q == ST_CAP_IR);
  wire ir_shift = (st_q == ST_SH_IR);
  wire ir_update = (st_q == ST_UPD_IR);
  // capture loads the fixed 01 pattern so a broken serial path shows up at once
  logic [BSP_IR_W-1:0] ir_sh_d;
  assign ir_sh_d = ir_capture ? {1'b0, BSP_IR_CAPTURE} : {tdi_s, ir_sh_q[BSP_IR_W-1:1]};

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ir_sh_q <= '0;
    end else if (tck_step && (ir_capture || ir_shift)) begin
      ir_sh_q <= ir_sh_d;
    end
  end

  // reset and update never coincide; reset is listed first as the safe choice
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      instr_active <= BSP_IR_IDCODE;
    end else if (tck_step && tap_reset) begin
      instr_active <= BSP_IR_IDCODE;
    end else if (tck_step && ir_update) begin
      instr_active <= ir_sh_q;
    end
  end

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  // the chain has no update stage at all, so nothing shifted in can leave it;
  // the pins and the rest of the device never see bsr_q
  wire dr_capture = (st_q == ST_CAP_DR);
  wire dr_shift = (st_q == ST_SH_DR);
  // update-dr and pause-dr fall outside both strobes, so every register holds
  wire dr_move = dr_capture | dr_shift;
  logic [BSR_W-1:0] bsr_d;
  logic [BSP_ID_W-1:0] id_d;
  logic byp_d;
  assign bsr_d = dr_capture ? pins_s : {tdi_s, bsr_q[BSR_W-1:1]};
  assign id_d = dr_capture ? ID_VALUE : {tdi_s, id_q[BSP_ID_W-1:1]};
  // bypass captures a zero, then delays tdi by exactly one tck
  assign byp_d = dr_capture ? 1'b0 : tdi_s;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bsr_q <= '0;
    end else if (tck_step && dr_move && sel_bsr) begin
      bsr_q <= bsr_d;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      id_q <= '0;
    end else if (tck_step && dr_move && sel_id) begin
      id_q <= id_d;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      byp_q <= 1'b0;
    end else if (tck_step && dr_move && sel_byp) begin
      byp_q <= byp_d;
    end
  end

  // ----------------------------------------
  // tdo driver
  // ----------------------------------------
  // tdo moves only at a detected fall, half a tck after the rise that shifted the
  // chain, so the far side always samples a settled bit at its next rise
  wire tdo_oe_n_d = ~in_shift;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tdo <= 1'b0;
    end else if (tck_drop) begin
      tdo <= out_bit;
    end
  end

  // the enable follows the state at the same fall, so tdo and its enable switch together;
  // it starts high so the pin stays released from power-up
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tdo_oe_n <= 1'b1;
    end else if (tck_drop) begin
      tdo_oe_n <= tdo_oe_n_d;
    end
  end
endmodule : bsp_tap

// *** tb/bsp_tap_assertions.sv ***
// Purpose: port checks for the scan port
// Assumes: tck high spans 4 clk_sys cycles, tck low at least 5
// Notes: bound to bsp_tap after the module
`timescale 1ns/1ps
module bsp_tap_assertions
  import bsp_pkg::*;
#(parameter int BSR_W = BSP_BSR_W) (
  // system
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // scan pins and levels
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic [BSR_W-1:0] pin_levels,
  input wire logic [BSP_IR_W-1:0] instr_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // tdo and its enable may only move once the synchronised fall has landed; the instruction moves after a rise
  sequence s_tck_low; !$past(tck) && !$past(tck, 2); endsequence
  property p_tdo_fall; $changed(tdo) |-> s_tck_low; endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved while tck high");
  property p_oe_fall; $changed(tdo_oe_n) |-> s_tck_low; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved while tck high");
  property p_ir_rise; $changed(instr_active) |-> $past(tck); endproperty
  a_ir_rise: assert property (p_ir_rise) else $error("instruction moved while tck low");
  property p_ir_hold; !tdo_oe_n |-> $stable(instr_active); endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("instruction moved during shift");
  // tdo holds for at least a tck phase once it has moved, and the enable once it has opened
  sequence s_tdo_held; $stable(tdo) [*5]; endsequence
  property p_tdo_held; $changed(tdo) |=> s_tdo_held; endproperty
  a_tdo_held: assert property (p_tdo_held) else $error("tdo did not hold for a tck phase");
  sequence s_oe_open; !tdo_oe_n [*6]; endsequence
  property p_oe_open; $fell(tdo_oe_n) |-> s_oe_open; endproperty
  a_oe_open: assert property (p_oe_open) else $error("tdo enable closed before the next fall");
  property p_ir_legal; !(instr_active inside {3'h3, 3'h5, 3'h6}); endproperty
  a_ir_legal: assert property (p_ir_legal) else $error("reserved instruction in force");
endmodule : bsp_tap_assertions
bind bsp_tap bsp_tap_assertions #(.BSR_W(BSR_W)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .clk_en(clk_en), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
  .pin_levels(pin_levels), .instr_active(instr_active));

// *** tb/bsp_ctl.sv ***
// Purpose: board scan controller model
// Assumes: 900 ns tck, stopped low between bits
// Notes: tdo taken at the rise, only while enabled
`timescale 1ns/1ps
module bsp_ctl (
  // system
  input wire logic clk_sys,
  // scan pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 900 ns period, well under the 10 MHz ceiling
  task automatic bit_t(input logic m, input logic d, output logic q);
    @(negedge clk_sys);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk_sys);
    q = tdo_oe_n ? 1'bx : tdo;
    tck = 1'b1;
    repeat (4) @(negedge clk_sys);
    tck = 1'b0;
    // hold time over: tdi no longer shows the bit
    tdi = ~d;
  endtask : bit_t
  // the bench loads defined codes only; no reserved code is ever scanned in
  task automatic scan(input logic ir, input int n, input logic [68:0] din, output logic [68:0] dout);
    logic q;
    dout = '0;
    bit_t(1'b1, 1'b1, q);
    if (ir) bit_t(1'b1, 1'b1, q);
    bit_t(1'b0, 1'b1, q);
    bit_t(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      bit_t(i == n - 1, din[i], q);
      dout[i] = q;
    end
    bit_t(1'b1, 1'b1, q);
    bit_t(1'b0, 1'b1, q);
  endtask : scan
endmodule : bsp_ctl

// *** tb/bsp_tap_test.sv ***
// Purpose: self-checking bench for the scan port
// Assumes: clk_sys 10 MHz, clk_en high except in the freeze test
// Notes: ir, sample and bypass scans with random data
`timescale 1ns/1ps
module bsp_tap_test
  import bsp_pkg::*;
;
  logic clk_sys, reset_n, clk_en, tck, tms, tdi, tdo, tdo_oe_n, q_idle;
  logic [BSP_BSR_W-1:0] pin_levels, din, dout;
  logic [BSP_IR_W-1:0] instr_active;
  // the controller loads defined codes only; reserved ones stay out of the list
  logic [2:0] codes [5] = '{BSP_IR_SAMPLE, BSP_IR_BYPASS, BSP_IR_EXTEST, BSP_IR_SAMPLEZ, BSP_IR_IDCODE};
  int err_count = 0;
  int comparisons = 0;
  bsp_tap uut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_levels(pin_levels), .instr_active(instr_active));
  bsp_ctl ctl (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // bypass: captured 0 first, then tdi one tck late
  function automatic logic [68:0] f_byp(logic [68:0] d, int n);
    return {d[67:0], 1'b0} & ((69'h1 << n) - 69'h1);
  endfunction : f_byp
  task automatic chk(string what, logic [68:0] exp, logic [68:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    #1_000_000;
    err_count++;
    summarize();
  end
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    pin_levels = '0;
    void'($urandom(32'h5C84E29D));
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("instr after reset", 69'(BSP_IR_IDCODE), 69'(instr_active));
    // leave test-logic-reset: every scan below starts and ends in run-test/idle
    ctl.bit_t(1'b0, 1'b1, q_idle);
    foreach (codes[k]) begin
      ctl.scan(1'b1, 3, 69'(codes[k]), dout);
      chk("ir capture", 69'h1, dout);
      chk("instr", 69'(codes[k]), 69'(instr_active));
      if (codes[k] == BSP_IR_BYPASS) begin
        din = BSP_BSR_W'($urandom & 32'hFF);
        ctl.scan(1'b0, 8, din, dout);
        chk("bypass path", f_byp(din, 8), dout);
      end else if (codes[k] == BSP_IR_IDCODE) begin
        ctl.scan(1'b0, BSP_ID_W, din, dout);
        chk("id chain", 69'(BSP_ID_DEFAULT), dout);
      end else begin
        // levels held still through capture, so no bit needs discarding
        pin_levels = BSP_BSR_W'({$urandom, $urandom, $urandom});
        for (int j = 0; j < 2; j++) begin
          din = BSP_BSR_W'({$urandom, $urandom, $urandom});
          ctl.scan(1'b0, BSP_BSR_W, din, dout);
          chk("sample chain", pin_levels, dout);
          chk("instr kept", 69'(codes[k]), 69'(instr_active));
          // a preload would hand back din on the next capture
          pin_levels = ~din;
        end
      end
      $display("test code %h done", codes[k]);
    end
    // clock enable low: a whole instruction scan must leave the port untouched
    repeat (4) @(negedge clk_sys);
    clk_en = 1'b0;
    ctl.scan(1'b1, 3, 69'(BSP_IR_BYPASS), dout);
    chk("instr frozen", 69'(BSP_IR_IDCODE), 69'(instr_active));
    clk_en = 1'b1;
    $display("test clock enable done");
    summarize();
  end
endmodule : bsp_tap_test
